// ==== shared/bsud_defs.svh ====
// Purpose: constants for the bus status and user display block
// Assumes: processor bus sampled on sys_clk (20 MHz), inputs synchronous
// Notes: user display locations are word addresses on a 24-bit byte bus
`ifndef BSUD_DEFS_SVH
`define BSUD_DEFS_SVH
`define BSUD_USER_LOW_ADDR 24'h090000
`define BSUD_USER_HIGH_ADDR 24'h0A0000
`define BSUD_ADDR_DIGITS 6
`define BSUD_DATA_DIGITS 4
`define BSUD_USER_DIGITS 6
`define BSUD_BAR_LEDS 10
`define BSUD_BLANK_DIGIT 5'h10
`endif

// ==== shared/bsud_pkg.sv ====
// Purpose: types for the bus status and user display block
// Assumes: nothing beyond the defs header
// Notes: step state machine encoding
package bsud_pkg;
  typedef enum logic [1:0] {
    BSUD_RUN = 2'b00,
    BSUD_HELD = 2'b01,
    BSUD_ADV = 2'b10
  } bsud_step_t;
endpackage : bsud_pkg

// ==== design/bsud_digit.sv ====
// Purpose: one hex digit driver with blanking
// Assumes: nibble is held stable by the caller
// Notes: blank code 5'h10 drives all segments off
`timescale 1ns/10ps
`default_nettype none
`include "bsud_defs.svh"
module bsud_digit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Digit value
  input wire logic [3:0] nibble,
  input wire logic lit,
  // Digit code: bit 4 set means blank
  output logic [4:0] code_ff
);
  // Registered so the display never glitches mid-update
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= `BSUD_BLANK_DIGIT;
    end else begin
      code_ff <= lit ? {1'b0, nibble} : `BSUD_BLANK_DIGIT; // Direct nibble, no BCD
    end
  end
endmodule : bsud_digit
`default_nettype wire

// ==== design/bsud_top.sv ====
// Purpose: display board logic: bus digits, user display, bargraphs, step gate
// Assumes: processor bus signals sampled synchronously to sys_clk
// Notes: digit outputs are 5-bit codes, 5'h10 = blank
`timescale 1ns/10ps
`default_nettype none
`include "bsud_defs.svh"
module bsud_top
  import bsud_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Mode controls from front panel logic
  input wire logic single_step,
  input wire logic step_all_cycles_mode,
  input wire logic step_press,
  // Processor bus
  input wire logic [23:0] cpu_addr,
  input wire logic [15:0] cpu_data,
  input wire logic as_n,
  input wire logic uds_n,
  input wire logic lds_n,
  input wire logic rw,
  input wire logic berr_n,
  input wire logic halt_n,
  input wire logic reset_n,
  input wire logic dtack_n,
  input wire logic vpa_n,
  input wire logic vma_n,
  input wire logic [2:0] fc,
  input wire logic br_n,
  input wire logic bg_n,
  input wire logic bgack_n,
  input wire logic [2:0] ipl_n,
  // Block selects for external-only stepping
  input wire logic board_block_select_1,
  input wire logic board_block_select_2,
  input wire logic board_block_select_3,
  input wire logic board_block_select_4,
  // Acknowledge to processor, open drain
  output logic dtack_out,
  output logic dtack_oe_n,
  // Step gate: high holds the processor cycle
  output logic cycle_hold,
  // Digits
  output logic [4:0] addr_digit [`BSUD_ADDR_DIGITS],
  output logic [4:0] data_digit [`BSUD_DATA_DIGITS],
  output logic [4:0] user_digit [`BSUD_USER_DIGITS],
  // Bargraphs
  output logic [9:0] bar_left_ff,
  output logic [9:0] bar_right_ff
);
  logic [15:0] user_low_ff;
  logic [7:0] user_high_ff;
  logic ack_ff;
  logic as_d_ff;
  logic [23:0] user_val;
  logic low_hit;
  logic high_hit;
  logic any_sel;
  logic step_hit;
  bsud_step_t step_ff;

  // Address decode for write cycles
  assign low_hit = !as_n && !rw && (cpu_addr == `BSUD_USER_LOW_ADDR);
  assign high_hit = !as_n && !rw && (cpu_addr == `BSUD_USER_HIGH_ADDR);

  // Low digits load on word writes only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_low_ff <= 16'h0000;
    end else if (low_hit && !uds_n && !lds_n) begin
      user_low_ff <= cpu_data;
    end
  end

  // High digits load on any write with the upper strobe, word or byte; the even byte rides on the upper lane
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_high_ff <= 8'h00;
    end else if (high_hit && !uds_n) begin
      user_high_ff <= cpu_data[15:8];
    end
  end

  // Acknowledge held while a write to either location lasts; reads get none
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (low_hit || high_hit) && (!uds_n || !lds_n);
    end
  end
  // Open drain: never drive high, external hardware acks its own selects
  assign dtack_out = 1'b0;
  assign dtack_oe_n = !ack_ff;

  // Strobe edge history for cycle-start detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      as_d_ff <= 1'b1;
    end else begin
      as_d_ff <= as_n;
    end
  end

  // Cycles that must wait for a press in the selected sub-mode
  assign any_sel = !board_block_select_1 || !board_block_select_2 ||
                   !board_block_select_3 || !board_block_select_4;
  assign step_hit = step_all_cycles_mode || any_sel;

  // One bus cycle per press; held until the strobe goes away
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_ff <= BSUD_RUN;
    end else begin
      unique case (step_ff)
        BSUD_RUN: begin
          if (single_step && !as_n && as_d_ff && step_hit) begin
            step_ff <= BSUD_HELD;
          end
        end
        BSUD_HELD: begin
          if (!single_step) begin
            step_ff <= BSUD_RUN;
          end else if (step_press) begin
            step_ff <= BSUD_ADV;
          end
        end
        BSUD_ADV: begin
          if (as_n) begin
            step_ff <= BSUD_RUN;
          end
        end
        default: begin
          step_ff <= BSUD_RUN;
        end
      endcase
    end
  end
  // Combinational so the hold starts in the cycle's first sampled strobe
  assign cycle_hold = (step_ff == BSUD_HELD) ||
                      (step_ff == BSUD_RUN && single_step && !as_n && as_d_ff && step_hit);

  // Bus digits, lit only in single-step
  genvar gi;
  generate
    for (gi = 0; gi < `BSUD_ADDR_DIGITS; gi++) begin : g_addr
      bsud_digit u_digit (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .nibble(cpu_addr[gi*4 +: 4]),
        .lit(single_step),
        .code_ff(addr_digit[gi])
      );
    end
    for (gi = 0; gi < `BSUD_DATA_DIGITS; gi++) begin : g_data
      bsud_digit u_digit (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .nibble(cpu_data[gi*4 +: 4]),
        .lit(single_step),
        .code_ff(data_digit[gi])
      );
    end
    for (gi = 0; gi < `BSUD_USER_DIGITS; gi++) begin : g_user
      bsud_digit u_digit (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .nibble(user_val[gi*4 +: 4]),
        .lit(1'b1), // Always lit
        .code_ff(user_digit[gi])
      );
    end
  endgenerate
  assign user_val = {user_high_ff, user_low_ff};

  // Bargraphs in both modes, lit on active level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bar_left_ff <= 10'h000;
      bar_right_ff <= 10'h000;
    end else begin
      bar_left_ff <= {!berr_n, !as_n, !halt_n, !uds_n, !reset_n,
                      !lds_n, !dtack_n, rw, !vpa_n, !vma_n};
      bar_right_ff <= {fc, !br_n, !bg_n, !bgack_n, ~ipl_n, 1'b0}; // Bitwise, one LED per level line
    end
  end

  // Checks
  user_low_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (low_hit && !uds_n && !lds_n) |=> user_low_ff == $past(cpu_data))
    else $error("low user digits not loaded");
  user_high_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (high_hit && !uds_n) |=> user_high_ff == $past(cpu_data[15:8]))
    else $error("high user digits not loaded");
  user_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(low_hit || high_hit) |=> $stable(user_low_ff) && $stable(user_high_ff))
    else $error("user digits changed without write");
  write_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (low_hit && !lds_n) |=> !dtack_oe_n)
    else $error("no acknowledge on user write");
  read_noack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rw |=> dtack_oe_n)
    else $error("acknowledge on read");
  addr_blank_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !single_step |=> addr_digit[0] == `BSUD_BLANK_DIGIT && data_digit[0] == `BSUD_BLANK_DIGIT)
    else $error("bus digits lit in free-run");
  addr_show_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    single_step |=> addr_digit[5] == {1'b0, $past(cpu_addr[23:20])} &&
                    data_digit[3] == {1'b0, $past(cpu_data[15:12])})
    else $error("bus digit wrong");
  user_lit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> user_digit[4] == {1'b0, $past(user_high_ff[3:0])})
    else $error("user digit not lit");
  rw_led_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> bar_left_ff[2] == $past(rw) && bar_left_ff[8] == !$past(as_n))
    else $error("bargraph level wrong");
  step_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step_ff == BSUD_HELD && single_step && !step_press) |=> cycle_hold)
    else $error("cycle released without press");
  step_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    step_ff == BSUD_HELD ##1 step_ff == BSUD_ADV ##[1:20] step_ff == BSUD_RUN);
  low_wr_c: cover property (@(posedge sys_clk) disable iff (!rst_n) low_hit && !uds_n && !lds_n);
  high_wr_c: cover property (@(posedge sys_clk) disable iff (!rst_n) high_hit && !uds_n);
endmodule : bsud_top
`default_nettype wire

// ==== sim/bsud_host.sv ====
// Purpose: host processor bus model for the display board
// Assumes: acknowledge sampled on rising sys_clk edges
// Notes: strobes held until acknowledge or a bounded wait runs out
`timescale 1ns/10ps
`default_nettype none
module bsud_host (
  // Clock and acknowledge
  input wire logic sys_clk,
  input wire logic dtack_oe_n,
  input wire logic cycle_hold,
  // Processor bus
  output logic [23:0] cpu_addr,
  output logic [15:0] cpu_data,
  output logic as_n,
  output logic uds_n,
  output logic lds_n,
  output logic rw
);
  // Idle bus: no strobes, read level
  initial begin
    cpu_addr = 24'h000000;
    cpu_data = 16'h0000;
    {as_n, uds_n, lds_n, rw} = 4'hF;
  end
  // One cycle; slow keeps strobes after the answer, data inverted once released
  task automatic cycle(input logic [23:0] a, input logic [15:0] d, input logic wr, input logic [1:0] strb,
                       input int slow, output logic ack);
    @(posedge sys_clk);
    #1;
    cpu_addr = a;
    cpu_data = d;
    rw = ~wr;
    {uds_n, lds_n} = ~strb;
    as_n = 0;
    ack = 0;
    // Other cycles are acked by outside hardware; a bounded wait stands in for it
    for (int i = 0; i < 8 && !ack; i++) begin
      @(posedge sys_clk);
      ack = (dtack_oe_n === 1'b0);
    end
    // Bus stays frozen while the step gate holds the cycle
    for (int i = 0; i < 64 && cycle_hold === 1'b1; i++) begin
      @(posedge sys_clk);
    end
    repeat (slow) @(posedge sys_clk);
    #1;
    {as_n, uds_n, lds_n, rw} = 4'hF;
    cpu_data = ~d;
  endtask : cycle
endmodule : bsud_host
`default_nettype wire

// ==== sim/bsud_top_test.sv ====
// Purpose: self-checking bench for the display board block
// Assumes: inputs change 1 ns after rising edges
// Notes: expected notes queued, a monitor process compares them
`timescale 1ns/10ps
`default_nettype none
`include "bsud_defs.svh"
module bsud_top_test import bsud_pkg::*;;
  logic sys_clk = 0, rst_n = 0, single_step = 0, step_all_cycles_mode = 0, step_press = 0;
  logic berr_n, halt_n, reset_n, dtack_n, vpa_n, vma_n, br_n, bg_n, bgack_n, dtack_out, dtack_oe_n, cycle_hold;
  logic board_block_select_1, board_block_select_2, board_block_select_3, board_block_select_4;
  logic [2:0] fc, ipl_n;
  logic [23:0] cpu_addr, v;
  logic [15:0] cpu_data;
  logic as_n, uds_n, lds_n, rw, ack;
  logic [4:0] addr_digit [`BSUD_ADDR_DIGITS], data_digit [`BSUD_DATA_DIGITS], user_digit [`BSUD_USER_DIGITS];
  logic [9:0] bar_left_ff, bar_right_ff;
  logic [29:0] note_q [$], obs, exp, u_obs, a_obs, d_obs;
  int mismatches = 0, checks = 0;
  integer seed = 22221;
  event seen;
  bsud_top bsud_top_i (.sys_clk, .rst_n, .single_step, .step_all_cycles_mode, .step_press, .cpu_addr, .cpu_data,
    .as_n, .uds_n, .lds_n, .rw, .berr_n, .halt_n, .reset_n, .dtack_n, .vpa_n, .vma_n, .fc, .br_n, .bg_n, .bgack_n,
    .ipl_n, .board_block_select_1, .board_block_select_2, .board_block_select_3, .board_block_select_4, .dtack_out,
    .dtack_oe_n, .cycle_hold, .addr_digit, .data_digit, .user_digit, .bar_left_ff, .bar_right_ff);
  bsud_host bsud_host_i (.sys_clk, .dtack_oe_n, .cycle_hold, .cpu_addr, .cpu_data, .as_n, .uds_n, .lds_n, .rw);
  // 20 MHz clock
  initial forever #25 sys_clk = ~sys_clk;
  // Digit codes packed, index 0 lowest
  always_comb for (int i = 0; i < 6; i++) begin
    u_obs[i*5+:5] = user_digit[i];
    a_obs[i*5+:5] = addr_digit[i];
    d_obs[i*5+:5] = (i < 4) ? data_digit[i] : 5'h00;
  end
  function automatic logic [29:0] codes(input logic [23:0] x, input int n, input logic lit);
    codes = 30'h0;
    for (int i = 0; i < n; i++) codes[i*5+:5] = lit ? {1'b0, x[i*4+:4]} : 5'h10;
  endfunction : codes
  task automatic look(input logic [29:0] e, input logic [29:0] o);
    note_q.push_back(e);
    obs = o;
    ->seen;
    #1;
  endtask : look
  // Monitor: oldest note against each observation
  initial forever begin
    @(seen);
    exp = note_q.pop_front();
    checks++;
    if (obs !== exp) begin
      mismatches++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, obs);
    end
  end
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Read cycle in single-step: checks mid-cycle, presses, then checks the gate dropped
  task automatic step_cycle(input logic [23:0] a, input logic [15:0] d, input logic held);
    fork
      bsud_host_i.cycle(a, d, 0, 2'b11, 0, ack);
      begin
        repeat (4) @(posedge sys_clk);
        #5;
        look(30'(cycle_hold), 30'(held));
        look(codes(a, 6, 1), a_obs);
        look(codes({8'h00, d}, 4, 1), d_obs);
        look(codes(v, 6, 1), u_obs);
        step_press = 1;
        @(posedge sys_clk);
        #1 step_press = 0;
        repeat (2) @(posedge sys_clk);
        #5;
        look(30'(cycle_hold), 30'h0);
      end
    join
  endtask : step_cycle
  // Watchdog, far beyond the expected run
  initial begin
    #300000;
    mismatches++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {berr_n, halt_n, reset_n, dtack_n, vpa_n, vma_n, br_n, bg_n, bgack_n, fc, ipl_n} = 15'h7FFF;
    {board_block_select_1, board_block_select_2, board_block_select_3, board_block_select_4} = 4'hF;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1;
    for (int n = 0; n < 24; n++) begin
      @(posedge sys_clk);
      #1;
      {berr_n, halt_n, reset_n, dtack_n, vpa_n, vma_n, fc, br_n, bg_n, bgack_n, ipl_n} = 15'($random(seed));
      {board_block_select_1, board_block_select_2, board_block_select_3, board_block_select_4} = 4'($random(seed));
      single_step = n[0];
      @(posedge sys_clk);
      #5;
      look({10'h0, ~berr_n, ~as_n, ~halt_n, ~uds_n, ~reset_n, ~lds_n, ~dtack_n, rw, ~vpa_n, ~vma_n},
           {10'h0, bar_left_ff});
      look({10'h0, fc, ~br_n, ~bg_n, ~bgack_n, ~ipl_n, 1'b0}, {10'h0, bar_right_ff});
      look(codes(cpu_addr, 6, single_step), a_obs);
      look(codes({8'h00, cpu_data}, 4, single_step), d_obs);
    end
    single_step = 0;
    $display("bargraph test done");
    for (int n = 0; n < 6; n++) begin
      v = (n == 0) ? 24'h123456 : 24'($random(seed));
      bsud_host_i.cycle(`BSUD_USER_LOW_ADDR, v[15:0], 1, 2'b11, n % 3, ack);
      look(30'(ack), 30'h1);
      look({29'h0, dtack_out}, 30'h0);
      bsud_host_i.cycle(`BSUD_USER_HIGH_ADDR, {v[23:16], 8'h00}, 1, 2'b10, n % 2, ack);
      look(30'(ack), 30'h1);
      repeat (2) @(posedge sys_clk);
      #5;
      look(codes(v, 6, 1), u_obs);
    end
    bsud_host_i.cycle(`BSUD_USER_LOW_ADDR, ~v[15:0], 1, 2'b01, 0, ack);
    look(30'(ack), 30'h1);
    bsud_host_i.cycle(`BSUD_USER_HIGH_ADDR, ~v[15:0], 1, 2'b01, 0, ack);
    look(30'(ack), 30'h1);
    bsud_host_i.cycle(`BSUD_USER_LOW_ADDR, ~v[15:0], 0, 2'b11, 0, ack);
    look(30'(ack), 30'h0);
    repeat (2) @(posedge sys_clk);
    #5;
    look(codes(v, 6, 1), u_obs);
    $display("user display test done");
    {board_block_select_1, board_block_select_2, board_block_select_3, board_block_select_4} = 4'hF;
    single_step = 1;
    step_all_cycles_mode = 1;
    step_cycle(24'h3C5A7E, 16'hB1D2, 1'b1);
    step_all_cycles_mode = 0;
    step_cycle(24'h3C5A80, 16'h2468, 1'b0);
    board_block_select_2 = 0;
    step_cycle(24'h0C0000, 16'h1357, 1'b1);
    $display("single step test done");
    report_and_stop();
  end
endmodule : bsud_top_test
`default_nettype wire
